// >>> design/t1cmp_pkg.sv
package t1cmp_pkg;

  // ****************************************
  // register addresses on the internal data bus
  // ****************************************
  localparam logic [5:0] ADDR_CMP_D = 6'h2A;
  localparam logic [5:0] ADDR_CMP_C = 6'h2B;
  localparam logic [5:0] ADDR_CMP_B = 6'h2C;
  localparam logic [5:0] ADDR_CMP_A = 6'h2D;
  localparam logic [5:0] ADDR_COUNT = 6'h2E;
  localparam logic [5:0] ADDR_CMP_MODE = 6'h2F;
  localparam logic [5:0] ADDR_WAVE_CTRL = 6'h30;
  localparam logic [5:0] ADDR_FORCE = 6'h31;
  localparam logic [5:0] ADDR_OVR_EN = 6'h32;
  localparam logic [5:0] ADDR_PORT_VAL = 6'h33;
  localparam logic [5:0] ADDR_FLAGS = 6'h38;
  localparam logic [5:0] ADDR_MASK = 6'h39;

  // ****************************************
  // field positions
  // ****************************************
  localparam int IRQ_CMP_D = 7;
  localparam int IRQ_CMP_A = 6;
  localparam int IRQ_CMP_B = 5;
  localparam int IRQ_OVF1 = 2;
  localparam int MODE_A_MSB = 7;
  localparam int WC_PWM = 0;
  localparam int WC_SIX = 1;
  localparam int WC_RUN = 2;
  localparam logic [7:0] FLAG_HW_BITS = 8'hE4;

  // ****************************************
  // reset values and vector addresses
  // ****************************************
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [7:0] TOP_RESET = 8'hFF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] VEC_CMP_D = 8'h10;
  localparam logic [7:0] VEC_CMP_A = 8'h03;
  localparam logic [7:0] VEC_CMP_B = 8'h09;
  localparam logic [7:0] VEC_OVF1 = 8'h04;
  localparam logic [7:0] VEC_NONE = 8'h00;

  // compare output mode encoding
  typedef enum logic [1:0] {
    COM_OFF = 2'b00,
    COM_TOGGLE = 2'b01,
    COM_CLEAR = 2'b10,
    COM_SET = 2'b11
  } t1cmp_com_e;

  // one cpu access on the internal data bus
  typedef struct packed {
    logic we;
    logic re;
    logic [5:0] addr;
    logic [7:0] wdata;
  } t1cmp_io_s;

endpackage

// >>> design/t1cmp_top.sv
`timescale 1ns/100ps

// Overview of operation
// - in non-pwm modes a force strobe acts like a real compare match
// - forced match sets no flag, keeps counter, but updates the waveform per mode
// - a count write blocks every compare match on the next timer tick
// - writing count equal to a compare value loses that match entirely
// - compare registers read back the most recently written buffered value
// - compare output mode fields act at once, without buffering
// - waveform latches keep their level across waveform mode changes
// - nonzero compare output mode replaces the port function of its pins
// - six override enables gate the pins; cleared shows the port value
// - six-output mode: mode zero disconnects pair, else pairs a and b take channel a and enable
// - mask register holds the four timer interrupt enables (bits 7, 6, 5, 2), reset zero
// - a request needs its mask bit, global enable and its event flag
// - compare d, a, b requests go to vectors 010, 003, 009
// - overflow sets its flag and, when enabled, goes to vector 004
// - compare d match sets flag bit 7
// - compare d flag clears on its vector or by writing one, one cycle late
module t1cmp_top
  import t1cmp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire t1cmp_io_s io_req,
  output logic [7:0] io_rdata,
  input wire logic t1_tick,
  input wire logic gie,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [7:0] irq_vector,
  output logic [5:0] pin_level
);

  // ****************************************
  // register state
  // ****************************************
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic block_reg;
  logic block_next;
  logic [7:0] cmp_buf_reg [0:3];
  logic [7:0] cmp_act_reg [0:3];
  logic [7:0] cmp_mode_reg;
  logic [7:0] wave_ctrl_reg;
  logic [5:0] ovr_en_reg;
  logic [5:0] port_val_reg;
  logic [7:0] mask_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] clr_pend_reg;
  logic [2:0] wave_reg;
  logic [2:0] wave_next;
  logic [7:0] rdata_next;
  logic [7:0] vector_next;
  logic [5:0] pin_next;

  // ****************************************
  // write decode
  // ****************************************
  wire [5:0] addr = io_req.addr;
  wire [7:0] wdata = io_req.wdata;
  wire wr_count = io_req.we && addr == ADDR_COUNT;
  wire wr_mode = io_req.we && addr == ADDR_CMP_MODE;
  wire wr_ctrl = io_req.we && addr == ADDR_WAVE_CTRL;
  wire wr_force = io_req.we && addr == ADDR_FORCE;
  wire wr_ovr = io_req.we && addr == ADDR_OVR_EN;
  wire wr_port = io_req.we && addr == ADDR_PORT_VAL;
  wire wr_flags = io_req.we && addr == ADDR_FLAGS;
  wire wr_mask = io_req.we && addr == ADDR_MASK;
  wire [3:0] wr_cmp = {io_req.we && addr == ADDR_CMP_D, io_req.we && addr == ADDR_CMP_C,
                       io_req.we && addr == ADDR_CMP_B, io_req.we && addr == ADDR_CMP_A};
  wire pwm = wave_ctrl_reg[WC_PWM];
  wire six = wave_ctrl_reg[WC_SIX];

  // force strobes live only in the write cycle and only outside pwm
  wire [2:0] force_pulse = (wr_force && !pwm) ? wdata[2:0] : 3'h0;

  // ****************************************
  // counter, blocking and matches
  // ****************************************
  wire tick = t1_tick && wave_ctrl_reg[WC_RUN];
  wire at_top = count_reg == cmp_act_reg[2];
  wire ovf_evt = tick && at_top && !wr_count;
  // a pending block swallows the whole next tick's matches
  wire match_ok = tick && !block_reg && !wr_count;
  wire [3:0] match = {match_ok && count_reg == cmp_act_reg[3], match_ok && count_reg == cmp_act_reg[2],
                      match_ok && count_reg == cmp_act_reg[1], match_ok && count_reg == cmp_act_reg[0]};

  // cpu write wins over counting; top wraps to zero
  assign count_next = wr_count ? wdata : (tick ? (at_top ? 8'h00 : count_reg + 8'h01) : count_reg);
  // block set by any count write, held until a tick consumes it
  assign block_next = wr_count ? 1'b1 : (tick ? 1'b0 : block_reg);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= CMP_RESET;
      block_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      block_reg <= block_next;
    end
  end

  // ****************************************
  // compare value buffers
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_cmp
      // buffer takes the write; active copy loads at once or at wrap in pwm
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          cmp_buf_reg[i] <= (i == 2) ? TOP_RESET : CMP_RESET;
          cmp_act_reg[i] <= (i == 2) ? TOP_RESET : CMP_RESET;
        end else begin
          if (wr_cmp[i]) begin
            cmp_buf_reg[i] <= wdata;
          end
          if (!pwm || ovf_evt) begin
            cmp_act_reg[i] <= cmp_buf_reg[i];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // waveform latches, channels a, b, d
  // ****************************************
  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_wave
      localparam int MSB = MODE_A_MSB - 2 * k;
      localparam int IDX = (k == 2) ? 3 : k;
      // mode read straight from its register, no shadow copy
      wire [1:0] mode = cmp_mode_reg[MSB -: 2];
      wire hit = match[IDX] || force_pulse[k];
      wire np_val = (mode == COM_TOGGLE) ? !wave_reg[k] : (mode == COM_SET);
      wire pw_hit = (mode == COM_SET);
      // mode change alone never touches the latch
      assign wave_next[k] = (mode == COM_OFF) ? wave_reg[k] :
                            (!pwm ? (hit ? np_val : wave_reg[k]) :
                            (match[IDX] ? pw_hit : (ovf_evt ? !pw_hit : wave_reg[k])));
    end
  endgenerate

  // ****************************************
  // pin override
  // ****************************************
  genvar p;
  generate
    for (p = 0; p < 6; p++) begin : g_pin
      localparam int CH = p / 2;
      wire [1:0] mode = cmp_mode_reg[MODE_A_MSB - 2 * CH -: 2];
      wire six_pair = six && CH < 2;
      // in six-output mode both pins of a and b follow channel a
      wire src = six_pair ? wave_reg[0] : wave_reg[CH];
      wire sig = (six_pair || p % 2 == 0) ? src : !src;
      // nonzero mode and set enable hand the pin to the compare signal
      assign pin_next[p] = (mode != COM_OFF && ovr_en_reg[p]) ? sig : port_val_reg[p];
    end
  endgenerate

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_mode_reg <= CTRL_RESET;
      wave_ctrl_reg <= CTRL_RESET;
      ovr_en_reg <= 6'h00;
      port_val_reg <= 6'h00;
      mask_reg <= MASK_RESET;
      wave_reg <= 3'h0;
      pin_level <= 6'h00;
    end else begin
      if (wr_mode) cmp_mode_reg <= {wdata[7:2], 2'h0};
      if (wr_ctrl) wave_ctrl_reg <= {5'h00, wdata[2:0]};
      if (wr_ovr) ovr_en_reg <= wdata[5:0];
      if (wr_port) port_val_reg <= wdata[5:0];
      if (wr_mask) mask_reg <= wdata;
      wave_reg <= wave_next;
      pin_level <= pin_next;
    end
  end

  // ****************************************
  // interrupt flags and dispatch
  // ****************************************
  wire [7:0] flag_set = {match[3], match[0], match[1], 2'h0, ovf_evt, 2'h0};
  wire [7:0] ack_clr = !irq_ack ? 8'h00 :
                       (irq_vector == VEC_CMP_D) ? 8'h80 :
                       (irq_vector == VEC_CMP_A) ? 8'h40 :
                       (irq_vector == VEC_CMP_B) ? 8'h20 :
                       (irq_vector == VEC_OVF1) ? 8'h04 : 8'h00;
  // a new event wins over either kind of clear
  assign flags_next = (flags_reg & ~(clr_pend_reg | ack_clr)) | flag_set;
  wire [7:0] pend = flags_reg & mask_reg & FLAG_HW_BITS;
  // lowest vector address first
  assign vector_next = pend[IRQ_CMP_A] ? VEC_CMP_A :
                       pend[IRQ_OVF1] ? VEC_OVF1 :
                       pend[IRQ_CMP_B] ? VEC_CMP_B :
                       pend[IRQ_CMP_D] ? VEC_CMP_D : VEC_NONE;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= FLAGS_RESET;
      clr_pend_reg <= 8'h00;
      irq_req <= 1'b0;
      irq_vector <= VEC_NONE;
    end else begin
      flags_reg <= flags_next;
      clr_pend_reg <= wr_flags ? (wdata & FLAG_HW_BITS) : 8'h00;
      irq_req <= gie && (pend != 8'h00);
      irq_vector <= gie ? vector_next : VEC_NONE;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  assign rdata_next = !io_req.re ? 8'h00 :
                      (addr == ADDR_CMP_A) ? cmp_buf_reg[0] :
                      (addr == ADDR_CMP_B) ? cmp_buf_reg[1] :
                      (addr == ADDR_CMP_C) ? cmp_buf_reg[2] :
                      (addr == ADDR_CMP_D) ? cmp_buf_reg[3] :
                      (addr == ADDR_COUNT) ? count_reg :
                      (addr == ADDR_CMP_MODE) ? cmp_mode_reg :
                      (addr == ADDR_WAVE_CTRL) ? wave_ctrl_reg :
                      (addr == ADDR_OVR_EN) ? {2'h0, ovr_en_reg} :
                      (addr == ADDR_PORT_VAL) ? {2'h0, port_val_reg} :
                      (addr == ADDR_FLAGS) ? flags_reg :
                      (addr == ADDR_MASK) ? mask_reg : 8'h00;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      io_rdata <= 8'h00;
    end else begin
      io_rdata <= rdata_next;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_force_wave;
    (force_pulse[0] && !match[0] && cmp_mode_reg[7:6] == COM_SET) |=> wave_reg[0];
  endproperty
  a_force_wave: assert property (p_force_wave) else $error("forced set missed");

  property p_force_no_flag;
    (force_pulse[0] && !match[0] && !flags_reg[IRQ_CMP_A] && !tick) |=> !flags_reg[IRQ_CMP_A] && $stable(count_reg);
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force touched flag");

  property p_block;
    (wr_count ##1 (tick && !wr_count)) |-> match == 4'h0;
  endproperty
  a_block: assert property (p_block) else $error("match after count write");

  property p_read_buf;
    (wr_cmp[0] ##1 (io_req.re && addr == ADDR_CMP_A && !wr_cmp[0])) |=> io_rdata == $past(io_req.wdata, 2);
  endproperty
  a_read_buf: assert property (p_read_buf) else $error("compare readback stale");

  property p_mode_now;
    (wr_mode && wdata[7:6] == COM_SET ##1 (match[0] && !pwm)) |=> wave_reg[0];
  endproperty
  a_mode_now: assert property (p_mode_now) else $error("mode write delayed");

  property p_mode_keep;
    (wr_ctrl && match == 4'h0 && force_pulse == 3'h0 && !ovf_evt) |=> $stable(wave_reg);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("wave moved on mode change");

  property p_pin_port;
    (cmp_mode_reg[7:6] == COM_OFF || !ovr_en_reg[0]) |=> pin_level[0] == $past(port_val_reg[0]);
  endproperty
  a_pin_port: assert property (p_pin_port) else $error("pin not port value");

  property p_six;
    (six && cmp_mode_reg[5:4] != COM_OFF) |=> pin_level[3] == $past(wave_reg[0] & ovr_en_reg[3] |
                                                   !ovr_en_reg[3] & port_val_reg[3]);
  endproperty
  a_six: assert property (p_six) else $error("six-output pin wrong");

  property p_irq_a;
    (gie && flags_reg[IRQ_CMP_A] && mask_reg[IRQ_CMP_A]) |=> irq_req && irq_vector == VEC_CMP_A;
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("compare a vector wrong");

  property p_no_irq;
    !gie |=> !irq_req;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("request without global enable");

  property p_ovf;
    ovf_evt |=> flags_reg[IRQ_OVF1];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag missing");

  property p_flag_d;
    match[3] |=> flags_reg[IRQ_CMP_D];
  endproperty
  a_flag_d: assert property (p_flag_d) else $error("compare d flag missing");

  property p_w1c_d;
    (wr_flags && wdata[IRQ_CMP_D] && flags_reg[IRQ_CMP_D] && !irq_ack) |=> flags_reg[IRQ_CMP_D]
      ##1 (flags_reg[IRQ_CMP_D] == $past(match[3]));
  endproperty
  a_w1c_d: assert property (p_w1c_d) else $error("compare d clear timing");

  property p_force_read;
    (io_req.re && addr == ADDR_FORCE) |=> io_rdata == 8'h00;
  endproperty
  a_force_read: assert property (p_force_read) else $error("force reads nonzero");

endmodule

// >>> testbench/t1cmp_load.sv
`timescale 1ns/100ps

// ****************************************
// external load on the six compare pins
// ****************************************
module t1cmp_load (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [5:0] pin_level,
  output logic [5:0] load_seen
);
  // the load sees the driven levels one cycle later
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      load_seen <= 6'h00;
    end else begin
      load_seen <= pin_level;
    end
  end
endmodule

// >>> testbench/timer1_compare_output_irq_test.sv
`timescale 1ns/100ps

module timer1_compare_output_irq_test;
  import t1cmp_pkg::*;
  // ****************************************
  // signals and instances
  // ****************************************
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } t1cmp_row_s;
  logic ref_clk;
  logic reset_n;
  t1cmp_io_s io_req;
  logic [7:0] io_rdata;
  logic t1_tick;
  logic gie;
  logic irq_ack;
  logic irq_req;
  logic [7:0] irq_vector;
  logic [5:0] pin_level;
  logic [5:0] load_seen;
  int error_cnt;
  int compares;
  t1cmp_row_s rows [7];
  logic [7:0] mode_seq [4];
  logic [7:0] pin_seq [4];

  t1cmp_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .io_req(io_req), .io_rdata(io_rdata),
    .t1_tick(t1_tick), .gie(gie), .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector),
    .pin_level(pin_level));
  t1cmp_load load (.ref_clk(ref_clk), .reset_n(reset_n), .pin_level(pin_level), .load_seen(load_seen));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      error_cnt++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // one register access, then one idle cycle; a read checks the answer
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [7:0] exp);
    io_req.we = w;
    io_req.re = !w;
    io_req.addr = a;
    io_req.wdata = d;
    cyc(1);
    io_req.we = 1'b0;
    io_req.re = 1'b0;
    if (!w) chk("io_rdata", io_rdata, exp);
    cyc(1);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 8'h00);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00, exp);
  endtask

  // two accesses on back-to-back edges, the second with an optional tick; checks the second answer
  task automatic pair(input t1cmp_io_s a, input t1cmp_io_s b, input logic tk, input logic [7:0] exp);
    io_req = a;
    cyc(1);
    io_req = b;
    t1_tick = tk;
    cyc(1);
    io_req = '0;
    t1_tick = 1'b0;
    chk("io_rdata", io_rdata, exp);
    cyc(1);
  endtask

  task automatic tick(input int n);
    t1_tick = 1'b1;
    cyc(n);
    t1_tick = 1'b0;
    cyc(3);
  endtask

  task automatic pins(input logic [7:0] exp);
    cyc(3);
    chk("load_seen", {2'b00, load_seen}, exp);
  endtask

  // bounded wait for a request, check its vector, then acknowledge it
  task automatic take_irq(input logic [7:0] vec);
    int n;
    n = 0;
    while (irq_req !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    if (irq_req !== 1'b1) begin
      $display("unexpected irq_req: expected 1, seen timeout");
      error_cnt++;
      finish_test();
    end
    chk("irq_vector", irq_vector, vec);
    irq_ack = 1'b1;
    cyc(1);
    irq_ack = 1'b0;
    cyc(3);
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // clock and main sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    error_cnt = 0;
    compares = 0;
    reset_n = 1'b0;
    io_req = '0;
    t1_tick = 1'b0;
    gie = 1'b0;
    irq_ack = 1'b0;
    rows = '{'{ADDR_CMP_A, 8'h05, 8'h05}, '{ADDR_CMP_B, 8'h05, 8'h05}, '{ADDR_CMP_D, 8'h05, 8'h05},
      '{ADDR_CMP_C, 8'hFF, 8'hFF}, '{ADDR_MASK, 8'hA5, 8'hA5}, '{ADDR_FORCE, 8'h07, 8'h00},
      '{6'h3F, 8'h5A, 8'h00}};
    mode_seq = '{8'h80, 8'h40, 8'h40, 8'hC0};
    pin_seq = '{8'h02, 8'h01, 8'h02, 8'h01};
    repeat (5) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    cyc(1);
    // reset values
    rd(ADDR_MASK, MASK_RESET);
    rd(ADDR_FLAGS, FLAGS_RESET);
    rd(ADDR_CMP_C, TOP_RESET);
    // ordinary cases, one byte per access
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].exp);
    end
    // wave level set by a force strobe before the pins are enabled
    wr(ADDR_CMP_MODE, 8'hC0);
    wr(ADDR_FORCE, 8'h01);
    wr(ADDR_OVR_EN, 8'h03);
    pins(8'h01);
    rd(ADDR_FLAGS, 8'h00);
    rd(ADDR_COUNT, 8'h00);
    // clear, toggle twice and set, each change followed by a force strobe
    foreach (mode_seq[i]) begin
      wr(ADDR_CMP_MODE, mode_seq[i]);
      wr(ADDR_FORCE, 8'h01);
      pins(pin_seq[i]);
    end
    // port values when the override is cleared or the mode is off
    wr(ADDR_OVR_EN, 8'h00);
    wr(ADDR_PORT_VAL, 8'h02);
    pins(8'h02);
    wr(ADDR_OVR_EN, 8'h03);
    wr(ADDR_CMP_MODE, 8'h00);
    pins(8'h02);
    // six-output mode with b enabled: b pins follow wave a; then plain pwm: level of wave a is kept
    wr(ADDR_CMP_MODE, 8'hF0);
    wr(ADDR_OVR_EN, 8'h0F);
    wr(ADDR_PORT_VAL, 8'h0C);
    wr(ADDR_WAVE_CTRL, 8'h02);
    pins(8'h0F);
    wr(ADDR_WAVE_CTRL, 8'h01);
    pins(8'h09);
    // count write equal to the compare values loses the match
    wr(ADDR_MASK, 8'hE4);
    wr(ADDR_WAVE_CTRL, 8'h04);
    wr(ADDR_COUNT, 8'h05);
    tick(1);
    rd(ADDR_FLAGS, 8'h00);
    wr(ADDR_COUNT, 8'h03);
    tick(4);
    rd(ADDR_FLAGS, 8'hE0);
    chk("irq_req", {7'h00, irq_req}, 8'h00);
    gie = 1'b1;
    take_irq(VEC_CMP_A);
    take_irq(VEC_CMP_B);
    chk("irq_vector", irq_vector, VEC_CMP_D);
    wr(ADDR_FLAGS, 8'h80);
    cyc(2);
    rd(ADDR_FLAGS, 8'h00);
    chk("irq_req", {7'h00, irq_req}, 8'h00);
    // counter wraps from top to zero
    wr(ADDR_COUNT, 8'hFE);
    tick(3);
    take_irq(VEC_OVF1);
    rd(ADDR_FLAGS, 8'h00);
    // back-to-back accesses: readback, blocked tick, immediate mode change
    pair(t1cmp_io_s'{1'b1, 1'b0, ADDR_CMP_A, 8'h40}, t1cmp_io_s'{1'b0, 1'b1, ADDR_CMP_A, 8'h00}, 1'b0, 8'h40);
    pair(t1cmp_io_s'{1'b1, 1'b0, ADDR_COUNT, 8'h05}, '0, 1'b1, 8'h00);
    rd(ADDR_FLAGS, 8'h00);
    wr(ADDR_CMP_A, 8'h06);
    wr(ADDR_CMP_MODE, 8'h80);
    wr(ADDR_FORCE, 8'h01);
    pair(t1cmp_io_s'{1'b1, 1'b0, ADDR_CMP_MODE, 8'hC0}, '0, 1'b1, 8'h00);
    pins(8'h0D);
    take_irq(VEC_CMP_A);
    // second reset in mid-run
    reset_n = 1'b0;
    cyc(2);
    reset_n = 1'b1;
    cyc(1);
    rd(ADDR_MASK, MASK_RESET);
    rd(ADDR_CMP_A, CMP_RESET);
    finish_test();
  end
endmodule
